// *** test/pit_host.sv ***
`timescale 1ns/1ns

// ****************************************************************
// Host model: Avalon master side of the register bus
// ****************************************************************
module pit_host (
  // Clock and answer
  input  wire logic  ref_clk,
  input  wire logic  avs_waitrequest,
  // Request
  output logic [5:0]  avs_address,
  output logic        avs_read,
  output logic        avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0]  avs_byteenable
);
  // Idle bus at time zero
  initial begin
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'h0;
  end

  // One access; held until a rising edge sees waitrequest low, and
  // released only after that edge
  task xfer(input logic w, input logic [5:0] a, input logic [7:0] d,
            input logic [3:0] be);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_byteenable <= be;
    avs_read <= !w;
    avs_write <= w;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_address <= ~a; // Released address and write data show no stale value
    avs_writedata <= ~{24'h000000, d};
  endtask
endmodule

// *** test/pit_top_props.sv ***
`timescale 1ns/1ns

// ****************************************************************
// Port checker for the interrupt and thermal block
// ****************************************************************
module pit_top_props (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  // Register bus
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_readdata,
  input  wire logic              avs_waitrequest,
  // Thermal and host pins
  input  wire logic [7:0]        die_temp_c,
  input  wire pit_pkg::pit_pwr_e pwr_state,
  input  wire logic              irq_out,
  input  wire logic              overtemp_cutoff,
  input  wire logic              restart_block
);
  // Single clock domain, so clock and reset are declared once
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // Interrupt pin in reset, bus timing, then thermal lockout relations
  AST_IRQ_RST: assert property (disable iff (1'b0) !rst_b ##1 !rst_b
    |-> irq_out)
    else $error("irq pin not idle during reset");
  AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("no answer one cycle after request");
  AST_WAIT_SHORT: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_RD_UPPER: assert property (avs_read && !avs_waitrequest
    |-> avs_readdata[31:8] == 24'h000000) else $error("upper read bits set");
  AST_LOCKOUT: assert property (restart_block == overtemp_cutoff)
    else $error("restart lockout differs from cutoff");
  AST_CUT_HOT: assert property ((die_temp_c > pit_pkg::CUTOFF_T &&
    pwr_state == pit_pkg::PIT_ACTIVE) [*2] |-> ##[0:2] overtemp_cutoff)
    else $error("no cutoff above shutdown temperature");
  AST_CUT_HOLD: assert property (overtemp_cutoff &&
    die_temp_c >= pit_pkg::WARN_T3 && pwr_state == pit_pkg::PIT_ACTIVE
    |=> overtemp_cutoff) else $error("cutoff released while still hot");
  AST_CUT_RISE: assert property ($rose(overtemp_cutoff)
    |-> $past(die_temp_c, 2) > pit_pkg::CUTOFF_T)
    else $error("cutoff raised below shutdown temperature");
  AST_CUT_OFF: assert property ((pwr_state == pit_pkg::PIT_OFF ||
    pwr_state == pit_pkg::PIT_BACKUP) [*3] |-> !overtemp_cutoff)
    else $error("thermal guard active in off or backup");
endmodule

bind pit_top pit_top_props u_props (.ref_clk(ref_clk), .rst_b(rst_b),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .die_temp_c(die_temp_c),
  .pwr_state(pwr_state), .irq_out(irq_out),
  .overtemp_cutoff(overtemp_cutoff), .restart_block(restart_block));

// *** test/tb_pit_top.sv ***
`timescale 1ns/1ns

// ****************************************************************
// Bench for the interrupt and thermal block
// ****************************************************************
module tb_pit_top;
  logic                     ref_clk = 1'b0;
  logic                     rst_b = 1'b0;
  logic [pit_pkg::NSRC-1:0] src_in = '0;
  logic [7:0]               die_temp_c = 8'h19;
  pit_pkg::pit_pwr_e        pwr_state = pit_pkg::PIT_ACTIVE;
  logic [5:0]               avs_address;
  logic                     avs_read;
  logic                     avs_write;
  logic [31:0]              avs_writedata;
  logic [3:0]               avs_byteenable;
  logic [31:0]              avs_readdata;
  logic                     avs_waitrequest;
  logic                     irq_out;
  logic                     sleep_block;
  logic                     overtemp_cutoff;
  logic [31:0]              r;
  logic [31:0]              q[$];
  integer                   seed = 49;
  integer                   n_mismatch = 0;
  integer                   comparisons = 0;

  pit_top dut (.ref_clk(ref_clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .src_in(src_in), .die_temp_c(die_temp_c), .pwr_state(pwr_state),
    .irq_out(irq_out), .sleep_block(sleep_block),
    .overtemp_cutoff(overtemp_cutoff), .restart_block());
  pit_host u_host (.ref_clk(ref_clk), .avs_waitrequest(avs_waitrequest),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable));

  // 250 MHz clock
  initial forever #2 ref_clk = ~ref_clk;

  task summarize;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] e);
    comparisons = comparisons + 1;
    if (got !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("wrong value at %0t: got %h exp %h", $time, got, e);
    end
  endtask

  // Read data is judged by the watcher against the oldest note
  task rd(input logic [5:0] a, input logic [7:0] e);
    q.push_back({24'h000000, e});
    u_host.xfer(1'b0, a, 8'h00, 4'hF);
  endtask
  task wr(input logic [5:0] a, input logic [7:0] d);
    u_host.xfer(1'b1, a, d, 4'hF);
  endtask
  // Event lines are slow to reach status, so each change gets 8 cycles
  task set_src(input logic [31:0] v);
    @(posedge ref_clk);
    src_in <= v;
    repeat (8) @(posedge ref_clk);
  endtask
  task set_t(input logic [7:0] v);
    @(posedge ref_clk);
    die_temp_c <= v;
    repeat (8) @(posedge ref_clk);
  endtask
  task set_p(input pit_pkg::pit_pwr_e v);
    @(posedge ref_clk);
    pwr_state <= v;
  endtask
  // Pins: interrupt, sleep block, cutoff
  task pin(input logic i, input logic b, input logic c);
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    chk({29'h0, irq_out, sleep_block, overtemp_cutoff}, {29'h0, i, b, c});
  endtask

  // Watcher of read answers
  always @(posedge ref_clk) begin
    if (avs_read && avs_waitrequest === 1'b0) chk(avs_readdata, q.pop_front());
  end

  // Watchdog far beyond the expected run
  initial begin
    #200000;
    n_mismatch = n_mismatch + 1;
    summarize;
  end

  initial begin
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge ref_clk);
    pin(1'b1, 1'b0, 1'b0);
    for (int g = 0; g < 4; g++) rd(6'(16 + 4 * g), 8'h00);
    rd(6'h30, 8'hFF);
    rd(6'h34, 8'h00);
    rd(6'h38, 8'h04);
    rd(6'h3C, 8'h00);
    // Random levels, then clear on read one word at a time
    r = $random(seed) | 32'h01010101;
    set_src(r);
    for (int g = 1; g < 4; g++) rd(6'(32 + 4 * g), r[8 * g +: 8]);
    pin(1'b0, 1'b1, 1'b0);
    rd(6'h04, r[15:8]);
    rd(6'h08, r[23:16]);
    rd(6'h04, 8'h00);
    rd(6'h00, r[7:0] & 8'hDF);
    rd(6'h0C, r[31:24]);
    pin(1'b1, 1'b0, 1'b0);
    // Masking before and after events; group four on falling edges
    wr(6'h14, 8'hFF);
    wr(6'h30, 8'h00);
    wr(6'h34, 8'hFF);
    set_src(r & 32'h000000FF);
    wr(6'h18, 8'hFF);
    wr(6'h1C, 8'hFF);
    pin(1'b1, 1'b0, 1'b0);
    rd(6'h04, 8'h00);
    rd(6'h08, r[23:16]);
    rd(6'h0C, r[31:24]);
    for (int g = 1; g < 4; g++) wr(6'(16 + 4 * g), 8'h00);
    // Pending kept, clear on write, active high
    wr(6'h38, 8'h07);
    set_src(src_in | 32'h00000100);
    set_src(src_in & ~32'h00000100);
    set_src(src_in | 32'h00000200);
    pin(1'b1, 1'b1, 1'b0);
    wr(6'h04, 8'h01);
    rd(6'h00, 8'h00);
    rd(6'h04, 8'h03);
    wr(6'h04, 8'h01);
    rd(6'h04, 8'h03);
    rd(6'h00, 8'h00);
    wr(6'h04, 8'h01);
    rd(6'h00, 8'h00);
    u_host.xfer(1'b1, 6'h04, 8'hFF, 4'h0);
    rd(6'h04, 8'h02);
    rd(6'h00, 8'h00);
    wr(6'h04, 8'hFF);
    pin(1'b0, 1'b0, 1'b0);
    // Pending dropped, another source still lands
    wr(6'h38, 8'h02);
    set_src(src_in | 32'h00010000);
    set_src(src_in & ~32'h00010000);
    set_src(src_in | 32'h00020000);
    rd(6'h08, 8'h03);
    rd(6'h04, 8'h00);
    wr(6'h08, 8'h03);
    rd(6'h04, 8'h00);
    rd(6'h08, 8'h00);
    pin(1'b1, 1'b0, 1'b0);
    // Warning, cutoff and lockout at the lowest threshold
    set_t(8'h78);
    rd(6'h00, 8'h20);
    set_t(8'h96);
    pin(1'b0, 1'b1, 1'b1);
    set_t(8'h7D);
    pin(1'b0, 1'b1, 1'b1);
    set_t(8'h70);
    pin(1'b0, 1'b1, 1'b0);
    rd(6'h04, 8'h00);
    wr(6'h00, 8'hFF);
    set_t(8'h6C);
    rd(6'h04, 8'h00);
    rd(6'h00, 8'h00);
    set_t(8'h69);
    rd(6'h04, 8'h00);
    rd(6'h00, 8'h20);
    rd(6'h04, 8'h00);
    wr(6'h00, 8'hFF);
    // Highest threshold
    wr(6'h3C, 8'h03);
    set_t(8'h80);
    rd(6'h00, 8'h00);
    set_t(8'h83);
    rd(6'h04, 8'h00);
    rd(6'h00, 8'h20);
    set_t(8'h14);
    rd(6'h04, 8'h00);
    wr(6'h00, 8'hFF);
    // Sleep: interrupt held back, cutoff disabled
    wr(6'h3C, 8'h0C);
    set_p(pit_pkg::PIT_SLEEP);
    set_src(src_in | 32'h00000100);
    set_t(8'h96);
    pin(1'b1, 1'b1, 1'b0);
    set_p(pit_pkg::PIT_ACTIVE);
    pin(1'b0, 1'b1, 1'b1);
    set_p(pit_pkg::PIT_OFF);
    pin(1'b1, 1'b1, 1'b0);
    summarize;
  end
endmodule

// *** verilog/pit_pkg.sv ***
package pit_pkg;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [5:0] OFS_FLAGS    = 6'h00; // Group status, 4 words
  localparam logic [5:0] OFS_SUPPRESS = 6'h10; // Group masks, 4 words
  localparam logic [5:0] OFS_LIVE     = 6'h20; // Group live levels
  localparam logic [5:0] OFS_EDGE_A   = 6'h30; // Group 4 rising enables
  localparam logic [5:0] OFS_EDGE_B   = 6'h34; // Group 4 falling enables
  localparam logic [5:0] OFS_IRQ_CTRL = 6'h38; // Polarity, clear, pending
  localparam logic [5:0] OFS_OSC_CFG  = 6'h3C; // Thermal and sleep setup

  // ****************************************************************
  // Sizes, field positions and reset values
  // ****************************************************************
  localparam int         GROUPS       = 4;
  localparam int         GBITS        = 8;
  localparam int         NSRC         = GROUPS * GBITS;
  localparam int         HEAT_BIT     = 5;   // Group 1, bit 5
  localparam logic [7:0] SUPPRESS_RST = 8'h00;
  localparam logic [7:0] EDGE_A_RST   = 8'hFF;
  localparam logic [7:0] EDGE_B_RST   = 8'h00;

  // ****************************************************************
  // Thermal figures in degrees Celsius
  // ****************************************************************
  localparam logic [7:0] WARN_T0   = 8'h75; // 117 C
  localparam logic [7:0] WARN_T1   = 8'h79; // 121 C
  localparam logic [7:0] WARN_T2   = 8'h7D; // 125 C
  localparam logic [7:0] WARN_T3   = 8'h82; // 130 C
  localparam logic [7:0] WARN_HYST = 8'h0A; // 10 C
  localparam logic [7:0] CUTOFF_T  = 8'h94; // 148 C

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    PIT_OFF,
    PIT_BACKUP,
    PIT_SLEEP,
    PIT_ACTIVE
  } pit_pwr_e;

  typedef struct packed {
    logic pend_en;       // Bit 2: keep one pending event per source
    logic clr_on_write;  // Bit 1: 0 = clear on read, 1 = clear on write
    logic active_high;   // Bit 0: interrupt output polarity
  } pit_irq_ctrl_s;

  typedef struct packed {
    logic       irq_sleep_mask;         // Bit 3: hold irq while asleep
    logic       sleep_overtemp_disable; // Bit 2
    logic [1:0] warn_temp_select;       // Bits 1:0
  } pit_osc_cfg_s;

  localparam pit_irq_ctrl_s IRQ_CTRL_RST = 3'h4;
  localparam pit_osc_cfg_s  OSC_CFG_RST  = 4'h0;

endpackage

// *** verilog/pit_top.sv ***
`timescale 1ns/1ns

// Functional notes
// RQ1 - Sources form four groups, each with status, mask and live-level word.
// RQ2 - Live-level register returns present level of every group input line; group one bit five returns the hot-die level instead.
// RQ3 - Group four has separate rising and falling edge enable registers.
// RQ4 - Unmasked set status bits OR onto one interrupt output, low by default.
// RQ5 - Masked source detects nothing; status unchanged, events lost.
// RQ6 - Status set before masking stays set until cleared; no new sets.
// RQ7 - Active interrupt is an on request blocking sleep until host clears.
// RQ8 - Control register picks output polarity and read or write clearing.
// RQ9 - Sleep mask bit decides whether interrupt is delivered while asleep.
// RQ10 - Pending enabled: repeat event held as one pending, later overwrite.
// RQ11 - Active plus pending needs two clearing accesses to clear status.
// RQ12 - Back-to-back clears of one register retire one event only.
// RQ13 - Pending disabled: repeat event on set source is dropped.
// RQ14 - Event on another source sets its own status at once.
// RQ15 - Output drops only when status clear; clear method applies to all.
// RQ16 - Clear on read: reading a status word clears its eight bits only.
// RQ17 - Clear on write: ones clear their bits, zeros leave bits alone.
// RQ18 - Host repeats the clearing pass while output still asserted.
// RQ19 - Thermal guard on except backup and off; config bit drops it asleep.
// RQ20 - Two-bit field selects one of four hot-die warning thresholds.
// RQ21 - Crossing threshold raises hot-die event, with ten degree hysteresis.
// RQ22 - Above 148 C switch off, log event, block restart below threshold.
// RQ23 - Hot-die event sits at group one bit five, both edges detected.
// RQ24 - Event in the same cycle as its clear is kept, never lost.
// RQ25 - Outside event inputs are synchronised before edge detection.
module pit_top (
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    rst_b,
  // Avalon-MM slave
  input  wire logic [5:0]              avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  input  wire logic [3:0]              avs_byteenable,
  output logic      [31:0]             avs_readdata,
  output logic                         avs_waitrequest,
  // Event lines and device state
  input  wire logic [pit_pkg::NSRC-1:0] src_in,
  input  wire logic [7:0]              die_temp_c,
  input  wire pit_pkg::pit_pwr_e       pwr_state,
  // Host and power sequencer signals
  output logic                         irq_out,
  output logic                         sleep_block,
  output logic                         overtemp_cutoff,
  output logic                         restart_block
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic [1:0] rst_sync_q;
  logic       rst_n;

  // Release through two stages so every flop leaves reset together
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'h1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ****************************************************************
  // Declarations
  // ****************************************************************
  localparam int N = pit_pkg::NSRC;

  logic [N-1:0]           s1_q, s2_q, s3_q, lvl_q, lvl_d1_q;
  logic [N-1:0]           rise_en, fall_en, ev, clr;
  logic [N-1:0]           flags_q, pend_q, suppress;
  logic [7:0]             suppress_q [pit_pkg::GROUPS];
  logic [7:0]             edge_a_q, edge_b_q;
  pit_pkg::pit_irq_ctrl_s irq_ctrl_q;
  pit_pkg::pit_osc_cfg_s  osc_cfg_q;
  logic                   hot_q, hot_d1_q, cut_q, cut_d1_q, guard_on;
  logic [7:0]             warn_t;
  logic                   irq_any, deliver, commit, same_reg;
  logic [5:0]             last_addr_q;
  logic [1:0]             grp;
  logic [31:0]            rd_d;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  // Three stages; a level counts only when the last two agree
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      lvl_q <= '0;
    end else begin
      s1_q  <= src_in;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & lvl_q); // RQ25
    end
  end

  // Previous levels for edge detection; hot-die replaces its line
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl_d1_q <= '0;
      hot_d1_q <= 1'h0;
      cut_d1_q <= 1'h0;
    end else begin
      lvl_d1_q <= lvl_q;
      hot_d1_q <= hot_q;
      cut_d1_q <= cut_q;
    end
  end

  // ****************************************************************
  // Thermal supervisor
  // ****************************************************************
  // Threshold selected by the two-bit warning field
  always_comb begin
    unique case (osc_cfg_q.warn_temp_select)
      2'h0: warn_t = pit_pkg::WARN_T0; // RQ20
      2'h1: warn_t = pit_pkg::WARN_T1;
      2'h2: warn_t = pit_pkg::WARN_T2;
      2'h3: warn_t = pit_pkg::WARN_T3;
    endcase
  end

  // Guard runs except in backup and off, and optionally not asleep
  assign guard_on = (pwr_state == pit_pkg::PIT_ACTIVE) ||                 // RQ19
                    (pwr_state == pit_pkg::PIT_SLEEP &&
                     !osc_cfg_q.sleep_overtemp_disable);

  // Hysteresis keeps one excursion to a single warning
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hot_q <= 1'h0;
    end else if (!guard_on) begin
      hot_q <= 1'h0;
    end else if (die_temp_c >= warn_t) begin
      hot_q <= 1'h1;                                                  // RQ21
    end else if (die_temp_c < warn_t - pit_pkg::WARN_HYST) begin
      hot_q <= 1'h0;                                                  // RQ21
    end
  end

  // Cutoff stays latched until the die cools below the warning level or power goes to off or backup
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cut_q <= 1'h0;
    end else if (guard_on && die_temp_c > pit_pkg::CUTOFF_T) begin
      cut_q <= 1'h1;                                                  // RQ22
    end else if (pwr_state == pit_pkg::PIT_OFF ||
                 pwr_state == pit_pkg::PIT_BACKUP ||
                 die_temp_c < warn_t) begin
      cut_q <= 1'h0;                                                  // RQ22
    end
  end

  // Switch-off request and restart lockout
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      overtemp_cutoff <= 1'h0;
      restart_block   <= 1'h0;
    end else begin
      overtemp_cutoff <= cut_q;                                       // RQ22
      restart_block   <= cut_q;
    end
  end

  // ****************************************************************
  // Event detection and status
  // ****************************************************************
  // Groups 1 to 3 see both edges; group 4 follows its enables
  assign rise_en = {edge_a_q, {(N - 8){1'h1}}};                       // RQ3
  assign fall_en = {edge_b_q, {(N - 8){1'h1}}};                       // RQ3
  assign suppress = {suppress_q[3], suppress_q[2],
                     suppress_q[1], suppress_q[0]};
  assign irq_any  = |(flags_q & ~suppress);                           // RQ4
  assign grp      = avs_address[3:2];
  assign commit   = (avs_read || avs_write) && !avs_waitrequest;
  // A second access to the same word retires nothing more
  assign same_reg = (avs_address == last_addr_q);                     // RQ12

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_src
      logic cur, prev, edge_hit, stay;
      if (gi == pit_pkg::HEAT_BIT) begin : g_heat
        assign cur  = hot_q;
        assign prev = hot_d1_q;
      end else begin : g_line
        assign cur  = lvl_q[gi];
        assign prev = lvl_d1_q[gi];
      end
      assign edge_hit = (cur & ~prev & rise_en[gi]) |
                        (~cur & prev & fall_en[gi]);                  // RQ23
      // Masked sources detect nothing; cutoff always leaves a record
      if (gi == pit_pkg::HEAT_BIT) begin : g_ev_heat
        assign ev[gi] = (edge_hit & ~suppress[gi]) |
                        (cut_q & ~cut_d1_q);                          // RQ22
      end else begin : g_ev_line
        assign ev[gi] = edge_hit & ~suppress[gi];                // RQ5 RQ14
      end
      // Clearing access: whole word on read, per bit on write
      assign clr[gi] = commit && !same_reg && avs_byteenable[0] &&
                       avs_address[5:4] == 2'h0 && grp == 2'(gi / 8) &&
                       (irq_ctrl_q.clr_on_write
                          ? (avs_write && avs_writedata[gi % 8])      // RQ17
                          : avs_read);                                // RQ16
      assign stay = flags_q[gi] & ~(clr[gi] & ~pend_q[gi]);           // RQ11

      // Status and single pending level per source
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          flags_q[gi] <= 1'h0;
          pend_q[gi]  <= 1'h0;
        end else begin
          flags_q[gi] <= stay | ev[gi];                               // RQ24
          pend_q[gi]  <= (pend_q[gi] & ~clr[gi]) |
                         (ev[gi] & stay & irq_ctrl_q.pend_en);   // RQ10 RQ13
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Interrupt output
  // ****************************************************************
  assign deliver = (pwr_state == pit_pkg::PIT_ACTIVE) ||
                   (pwr_state == pit_pkg::PIT_SLEEP &&
                    !osc_cfg_q.irq_sleep_mask);                       // RQ9

  // Pin idles at the inactive level of the selected polarity
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_out     <= 1'h1;
      sleep_block <= 1'h0;
    end else begin
      irq_out     <= (irq_any && deliver) ~^ irq_ctrl_q.active_high; // RQ8
      sleep_block <= irq_any;                                         // RQ7
    end
  end

  // ****************************************************************
  // Register writes
  // ****************************************************************
  // Only the low byte carries data; other lanes are ignored
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int g = 0; g < pit_pkg::GROUPS; g++) begin
        suppress_q[g] <= pit_pkg::SUPPRESS_RST;
      end
      edge_a_q   <= pit_pkg::EDGE_A_RST;
      edge_b_q   <= pit_pkg::EDGE_B_RST;
      irq_ctrl_q <= pit_pkg::IRQ_CTRL_RST;
      osc_cfg_q  <= pit_pkg::OSC_CFG_RST;
    end else if (commit && avs_write && avs_byteenable[0]) begin
      if (avs_address[5:4] == pit_pkg::OFS_SUPPRESS[5:4]) begin
        suppress_q[grp] <= avs_writedata[7:0];                        // RQ6
      end
      if (avs_address == pit_pkg::OFS_EDGE_A) begin
        edge_a_q <= avs_writedata[7:0];
      end
      if (avs_address == pit_pkg::OFS_EDGE_B) begin
        edge_b_q <= avs_writedata[7:0];
      end
      if (avs_address == pit_pkg::OFS_IRQ_CTRL) begin
        irq_ctrl_q <= avs_writedata[2:0];                             // RQ15
      end
      if (avs_address == pit_pkg::OFS_OSC_CFG) begin
        osc_cfg_q <= avs_writedata[3:0];
      end
    end
  end

  // Remember the last word touched, for the back-to-back check
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_addr_q <= 6'h3F;
    end else if (commit) begin
      last_addr_q <= avs_address;
    end
  end

  // ****************************************************************
  // Register reads and bus handshake
  // ****************************************************************
  // Read mux; bits above each register's field answer zero
  always_comb begin
    rd_d = 32'h0;
    unique case (avs_address[5:4])
      2'h0: rd_d[7:0] = flags_q[grp*8 +: 8];                          // RQ1
      2'h1: rd_d[7:0] = suppress_q[grp];
      2'h2: begin
        rd_d[7:0] = lvl_q[grp*8 +: 8];                                // RQ2
        if (grp == 2'h0) begin
          rd_d[pit_pkg::HEAT_BIT] = hot_q;
        end
      end
      2'h3: begin
        if (avs_address == pit_pkg::OFS_EDGE_A) begin
          rd_d[7:0] = edge_a_q;
        end else if (avs_address == pit_pkg::OFS_EDGE_B) begin
          rd_d[7:0] = edge_b_q;
        end else if (avs_address == pit_pkg::OFS_IRQ_CTRL) begin
          rd_d[2:0] = irq_ctrl_q;
        end else begin
          rd_d[3:0] = osc_cfg_q;
        end
      end
    endcase
  end

  // One wait cycle per access; data stands when waitrequest drops
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'h1;
      avs_readdata    <= 32'h0;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= rd_d;
      end
    end
  end

endmodule
